// ### hdl/tsc_device.sv
/*
 * Transceiver end: status word with read-to-clear flags and the general
 * configuration register, reached over the serial command link.
 * Assumes radio-side status inputs come from logic on mclk_i, except the
 * external interrupt pin, which is asynchronous.
 */
`timescale 1ns/100ps
module tsc_device #(
    parameter int FIFO_CNT_W = tsc_pkg::FIFO_CNT_W
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Serial link
    tsc_link_if.dev_mp link,
    // Radio mode and events
    input wire logic tx_mode_i,
    input wire logic tx_reg_ready_i,
    input wire logic tx_underrun_i,
    input wire logic rx_overflow_i,
    input wire logic wakeup_overflow_i,
    input wire logic ext_interrupt_data_indicator_pin_i,
    input wire logic afc_cycle_done_i,
    // Radio levels
    input wire logic [FIFO_CNT_W-1:0] rx_fifo_count_i,
    input wire logic [FIFO_CNT_W-1:0] fifo_fill_level_i,
    input wire logic low_battery_i,
    input wire logic signal_strength_i,
    input wire logic data_quality_i,
    input wire logic clock_recovery_lock_i,
    input wire logic offset_sign_i,
    input wire logic [3:0] offset_value_i,
    // Received bit stream
    input wire logic rx_data_i,
    input wire logic rx_clk_i,
    // Configuration outputs
    output logic tx_data_register_enable_o,
    output logic rx_fifo_enable_o,
    output logic [1:0] band_select_o,
    output logic [3:0] crystal_load_select_o,
    // Received data routing
    output logic rx_fifo_bit_o,
    output logic rx_fifo_bit_valid_o,
    output logic data_modulation_pin_o,
    output logic data_modulation_pin_oe_o,
    output logic recovered_clock_pin_o,
    output logic recovered_clock_pin_oe_o
);
    import tsc_pkg::*;

    logic nsel_s, sck_s, sdi_s, ext_s;
    logic nsel_q_r, sck_q_r, ext_q_r;
    logic por_pending_r;
    logic fill_flag_r, por_flag_r, uo_flag_r, wut_flag_r, ext_flag_r, afc_toggle_r;
    logic [7:0] cfg_r;
    logic [FRAME_BITS-1:0] rx_sr_r, tx_sr_r;
    logic [BIT_CNT_W-1:0] bit_cnt_r;
    logic [FRAME_BITS-1:0] status_word, word_in;
    logic frame_start, frame_end, sck_rise, sck_fall, frame_done;
    logic status_clr, cfg_wr, fill_set, uo_set, ext_fall, txrdy_now;
    logic sdo_r, sdo_oe_r;

    // Pins from the host and the interrupt pin are asynchronous; reset to idle
    // levels so no false clock edge follows reset
    tsc_sync2 #(.WIDTH(SYNC_W), .RST_VAL(4'h9)) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i({link.nsel, link.sck, link.sdi, ext_interrupt_data_indicator_pin_i}),
        .q_o({nsel_s, sck_s, sdi_s, ext_s})
    );

    // Previous synchronised levels for edge detection
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            nsel_q_r <= 1'b1;
            sck_q_r <= 1'b0;
            ext_q_r <= 1'b1;
        end else begin
            nsel_q_r <= nsel_s;
            sck_q_r <= sck_s;
            ext_q_r <= ext_s;
        end
    end

    // Link events and command decode
    assign frame_start = nsel_q_r && !nsel_s;
    assign frame_end = !nsel_q_r && nsel_s;
    assign sck_rise = !nsel_s && !sck_q_r && sck_s;
    assign sck_fall = !nsel_s && sck_q_r && !sck_s;
    assign word_in = {rx_sr_r[FRAME_BITS-2:0], sdi_s};
    assign frame_done = sck_rise && (bit_cnt_r == LAST_BIT);
    assign status_clr = frame_done && (word_in[CMD_MSB] == CMD_FIRST_READ);
    assign cfg_wr = frame_done && (word_in[CMD_MSB:CMD_LSB] == CMD_GEN_CFG);
    assign ext_fall = ext_q_r && !ext_s;

    // Mode dependent event sources; transmit readiness needs the register on
    assign txrdy_now = tx_reg_ready_i && cfg_r[CFG_TX_DATA_REGISTER_ENABLE];
    assign fill_set = tx_mode_i ? txrdy_now : (rx_fifo_count_i >= fifo_fill_level_i);
    assign uo_set = tx_mode_i ? tx_underrun_i : rx_overflow_i;

    // Sticky flags: a set in the clearing cycle wins, so that event stays for the next read
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            fill_flag_r <= STATUS_RST[STS_TXRDY_FILL];
            uo_flag_r <= STATUS_RST[STS_UNDER_OVER];
            wut_flag_r <= STATUS_RST[STS_WAKEUP];
            ext_flag_r <= STATUS_RST[STS_EXT_EDGE];
        end else begin
            fill_flag_r <= (fill_flag_r && !status_clr) || fill_set;
            uo_flag_r <= (uo_flag_r && !status_clr) || uo_set;
            wut_flag_r <= (wut_flag_r && !status_clr) || wakeup_overflow_i;
            ext_flag_r <= (ext_flag_r && !status_clr) || ext_fall;
        end
    end

    // Power-on flag rises one cycle after reset release, so reset shows zero
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            por_pending_r <= 1'b1;
            por_flag_r <= STATUS_RST[STS_POR];
        end else begin
            por_pending_r <= 1'b0;
            por_flag_r <= (por_flag_r && !status_clr) || por_pending_r;
        end
    end

    // AFC cycle toggle
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            afc_toggle_r <= STATUS_RST[STS_AFC_TOGGLE];
        end else if (afc_cycle_done_i) begin
            afc_toggle_r <= !afc_toggle_r;
        end
    end

    // Status word assembly; offset is passed through, not latched
    always_comb begin
        status_word = STATUS_RST;
        status_word[STS_TXRDY_FILL] = fill_flag_r;
        status_word[STS_POR] = por_flag_r;
        status_word[STS_UNDER_OVER] = uo_flag_r;
        status_word[STS_WAKEUP] = wut_flag_r;
        status_word[STS_EXT_EDGE] = ext_flag_r;
        status_word[STS_LOW_BATT] = low_battery_i;
        status_word[STS_FIFO_EMPTY] = (rx_fifo_count_i == '0);
        status_word[STS_SIGNAL] = signal_strength_i;
        status_word[STS_QUALITY] = data_quality_i;
        status_word[STS_CLK_LOCK] = clock_recovery_lock_i;
        status_word[STS_AFC_TOGGLE] = afc_toggle_r;
        status_word[STS_OFF_SIGN] = offset_sign_i;
        status_word[STS_OFF_MSB:STS_OFF_LSB] = offset_value_i;
    end

    // Receive shift register and bit counter
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rx_sr_r <= '0;
            bit_cnt_r <= '0;
        end else if (frame_start) begin
            bit_cnt_r <= '0;
        end else if (sck_rise) begin
            rx_sr_r <= word_in;
            bit_cnt_r <= bit_cnt_r + 1'b1;
        end
    end

    // Transmit shift: whole status captured at frame start, MSB first
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            tx_sr_r <= STATUS_RST;
            sdo_r <= 1'b1;
            sdo_oe_r <= 1'b0;
        end else if (frame_start) begin
            tx_sr_r <= status_word;
            sdo_r <= status_word[FRAME_BITS-1];
            sdo_oe_r <= 1'b1;
        end else if (frame_end) begin
            sdo_oe_r <= 1'b0;
        end else if (sck_fall) begin
            tx_sr_r <= {tx_sr_r[FRAME_BITS-2:0], 1'b0};
            sdo_r <= tx_sr_r[FRAME_BITS-2];
        end
    end
    assign link.sdo = sdo_r;
    assign link.sdo_oe = sdo_oe_r;

    // General configuration register, written by code 0x80
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            cfg_r <= GEN_CFG_RST[7:0];
        end else if (cfg_wr) begin
            cfg_r <= word_in[7:0];
        end
    end

    // Configuration outputs; reserved band code passed on as written
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            tx_data_register_enable_o <= GEN_CFG_RST[CFG_TX_DATA_REGISTER_ENABLE];
            rx_fifo_enable_o <= GEN_CFG_RST[CFG_RX_FIFO_ENABLE];
            band_select_o <= GEN_CFG_RST[CFG_BAND_MSB:CFG_BAND_LSB];
            crystal_load_select_o <= GEN_CFG_RST[CFG_LOAD_MSB:CFG_LOAD_LSB];
        end else begin
            tx_data_register_enable_o <= cfg_r[CFG_TX_DATA_REGISTER_ENABLE];
            rx_fifo_enable_o <= cfg_r[CFG_RX_FIFO_ENABLE];
            band_select_o <= cfg_r[CFG_BAND_MSB:CFG_BAND_LSB];
            crystal_load_select_o <= cfg_r[CFG_LOAD_MSB:CFG_LOAD_LSB];
        end
    end

    // Received data goes to the FIFO or out on the data and clock pins
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            rx_fifo_bit_o <= 1'b0;
            rx_fifo_bit_valid_o <= 1'b0;
            data_modulation_pin_o <= 1'b0;
            data_modulation_pin_oe_o <= 1'b0;
            recovered_clock_pin_o <= 1'b0;
            recovered_clock_pin_oe_o <= 1'b0;
        end else begin
            rx_fifo_bit_o <= rx_data_i;
            rx_fifo_bit_valid_o <= cfg_r[CFG_RX_FIFO_ENABLE] && rx_clk_i;
            data_modulation_pin_o <= rx_data_i;
            data_modulation_pin_oe_o <= !cfg_r[CFG_RX_FIFO_ENABLE];
            recovered_clock_pin_o <= rx_clk_i;
            recovered_clock_pin_oe_o <= !cfg_r[CFG_RX_FIFO_ENABLE];
        end
    end
endmodule // tsc_device

// ### hdl/tsc_host.sv
/*
 * Host end: sends one sixteen-bit command frame per request and returns
 * the word shifted back, which is the status word for a status read.
 * Assumes the device answers within a few cycles of each clock edge.
 */
`timescale 1ns/100ps
module tsc_host #(
    parameter int HALF_CYC = tsc_pkg::SCK_HALF_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Serial link
    tsc_link_if.host_mp link,
    // Command request
    input wire logic cmd_valid_i,
    input wire logic [15:0] cmd_word_i,
    input wire logic afc_enable_i,
    // Answer
    output logic busy_o,
    output logic done_o,
    output logic [15:0] rd_data_o,
    output logic offset_trusted_o
);
    import tsc_pkg::*;

    tsc_host_state_t state_r;
    logic [15:0] div_r;
    logic tick;
    logic [FRAME_BITS-1:0] out_sr_r, in_sr_r;
    logic [BIT_CNT_W-1:0] bit_cnt_r;
    logic is_read_r;
    logic sdo_s;
    logic nsel_r, sck_r, sdi_r;

    // Returned data line is a pin from the other party
    tsc_sync2 #(.WIDTH(1), .RST_VAL(1'b1)) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i(link.sdo_line),
        .q_o(sdo_s)
    );

    // Half-period enable for the serial clock
    assign tick = (div_r == 16'(HALF_CYC - 1));
    always_ff @(posedge mclk_i) begin
        if (!nrst_i || state_r == TSC_H_IDLE || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 16'h0001;
        end
    end

    // Frame sequencer
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            state_r <= TSC_H_IDLE;
            nsel_r <= 1'b1;
            sck_r <= 1'b0;
            sdi_r <= 1'b0;
            out_sr_r <= '0;
            in_sr_r <= '0;
            bit_cnt_r <= '0;
            is_read_r <= 1'b0;
        end else begin
            unique case (state_r)
                TSC_H_IDLE: begin
                    if (cmd_valid_i) begin
                        out_sr_r <= cmd_word_i;
                        sdi_r <= cmd_word_i[FRAME_BITS-1];
                        is_read_r <= (cmd_word_i[CMD_MSB] == CMD_FIRST_READ);
                        nsel_r <= 1'b0;
                        bit_cnt_r <= '0;
                        state_r <= TSC_H_LOW;
                    end
                end
                TSC_H_LOW: begin
                    if (tick) begin
                        // Sample late in the low phase, after the sync delay
                        in_sr_r <= {in_sr_r[FRAME_BITS-2:0], sdo_s};
                        sck_r <= 1'b1;
                        state_r <= TSC_H_HIGH;
                    end
                end
                TSC_H_HIGH: begin
                    if (tick) begin
                        sck_r <= 1'b0;
                        bit_cnt_r <= bit_cnt_r + 1'b1;
                        out_sr_r <= {out_sr_r[FRAME_BITS-2:0], 1'b0};
                        sdi_r <= out_sr_r[FRAME_BITS-2];
                        state_r <= (bit_cnt_r == LAST_BIT) ? TSC_H_END : TSC_H_LOW;
                    end
                end
                TSC_H_END: begin
                    if (tick) begin
                        nsel_r <= 1'b1;
                        state_r <= TSC_H_GAP;
                    end
                end
                TSC_H_GAP: begin
                    if (tick) begin
                        state_r <= TSC_H_IDLE;
                    end
                end
                default: begin
                    state_r <= TSC_H_IDLE;
                end
            endcase
        end
    end
    assign link.nsel = nsel_r;
    assign link.sck = sck_r;
    assign link.sdi = sdi_r;

    // Answer; offset field only trusted for a read with the AFC off in the cycle the answer is taken
    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            rd_data_o <= '0;
            offset_trusted_o <= 1'b0;
        end else begin
            busy_o <= (state_r != TSC_H_IDLE) || cmd_valid_i;
            done_o <= (state_r == TSC_H_END) && tick;
            if ((state_r == TSC_H_END) && tick) begin
                rd_data_o <= in_sr_r;
                offset_trusted_o <= is_read_r && !afc_enable_i;
            end
        end
    end
endmodule // tsc_host

// ### hdl/tsc_link_if.sv
/*
 * Serial command link between host and transceiver.
 * Assumes the serial data out line idles high through a pull-up when the
 * device does not drive it.
 */
`timescale 1ns/100ps
interface tsc_link_if;
    logic nsel;
    logic sck;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic sdo_line;

    // Resolved level of the device data line
    assign sdo_line = sdo_oe ? sdo : 1'b1;

    modport dev_mp (input nsel, input sck, input sdi, output sdo, output sdo_oe);
    modport host_mp (output nsel, output sck, output sdi, input sdo_line);
endinterface

// ### hdl/tsc_pkg.sv
/*
 * Shared constants for the transceiver status / general configuration link:
 * frame length, command codes, status and configuration field positions,
 * reset values and host link timing.
 * Assumes both link ends and the bench import it whole.
 */
package tsc_pkg;

    // Frame layout
    localparam int FRAME_BITS = 16;
    localparam int BIT_CNT_W = 5;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h0f;
    localparam int CMD_MSB = 15;
    localparam int CMD_LSB = 8;
    localparam logic [7:0] CMD_GEN_CFG = 8'h80;
    localparam logic CMD_FIRST_WRITE = 1'b1;
    localparam logic CMD_FIRST_READ = 1'b0;
    localparam logic [15:0] CMD_STATUS_READ = 16'h0000;

    // Reset values
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [15:0] GEN_CFG_RST = 16'h8008;

    // Status word bit positions
    localparam int STS_TXRDY_FILL = 15;
    localparam int STS_POR = 14;
    localparam int STS_UNDER_OVER = 13;
    localparam int STS_WAKEUP = 12;
    localparam int STS_EXT_EDGE = 11;
    localparam int STS_LOW_BATT = 10;
    localparam int STS_FIFO_EMPTY = 9;
    localparam int STS_SIGNAL = 8;
    localparam int STS_QUALITY = 7;
    localparam int STS_CLK_LOCK = 6;
    localparam int STS_AFC_TOGGLE = 5;
    localparam int STS_OFF_SIGN = 4;
    localparam int STS_OFF_MSB = 3;
    localparam int STS_OFF_LSB = 0;

    // General configuration field positions
    localparam int CFG_TX_DATA_REGISTER_ENABLE = 7;
    localparam int CFG_RX_FIFO_ENABLE = 6;
    localparam int CFG_BAND_MSB = 5;
    localparam int CFG_BAND_LSB = 4;
    localparam int CFG_LOAD_MSB = 3;
    localparam int CFG_LOAD_LSB = 0;

    // Band codes
    localparam logic [1:0] BAND_RESERVED = 2'h0;
    localparam logic [1:0] BAND_433 = 2'h1;
    localparam logic [1:0] BAND_868 = 2'h2;
    localparam logic [1:0] BAND_915 = 2'h3;

    // Link timing: 800 ns half period of the serial clock at 10 MHz
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCK_HALF_NS = 800;
    localparam int SCK_HALF_CYC = SCK_HALF_NS / CLK_PERIOD_NS;
    localparam int FIFO_CNT_W = 4;
    localparam int SYNC_W = 4;

    // Host sequencer states
    typedef enum logic [2:0] {
        TSC_H_IDLE = 3'b000,
        TSC_H_LOW = 3'b001,
        TSC_H_HIGH = 3'b010,
        TSC_H_END = 3'b011,
        TSC_H_GAP = 3'b100
    } tsc_host_state_t;

endpackage

// ### hdl/tsc_sync2.sv
/*
 * Two-flop synchroniser, one chain per bit.
 * Assumes inputs are asynchronous levels; only the second stage is read.
 */
`timescale 1ns/100ps
module tsc_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_r;

    // One chain per bit
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            always_ff @(posedge mclk_i) begin
                if (!nrst_i) begin
                    meta_r[gi] <= RST_VAL[gi];
                    q_o[gi] <= RST_VAL[gi];
                end else begin
                    meta_r[gi] <= d_i[gi];
                    q_o[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate
endmodule // tsc_sync2

// ### testbench/transceiver_status_and_general_config_tb_top.sv
/*
 * Bench: host and device ends joined over the link interface, radio side
 * driven from here, each scenario judged by its own task.
 * Assumes the package defaults for frame length and serial timing.
 */
`timescale 1ns/100ps
module transceiver_status_and_general_config_tb_top;
    import tsc_pkg::*;
    logic mclk_i = 1'b0, nrst_i = 1'b0, cmd_valid_i = 1'b0, afc_enable_i = 1'b1;
    logic tx_mode_i = 1'b0, tx_reg_ready_i = 1'b0, tx_underrun_i = 1'b0;
    logic rx_overflow_i = 1'b0, wakeup_overflow_i = 1'b0, afc_cycle_done_i = 1'b0;
    logic ext_interrupt_data_indicator_pin_i = 1'b1, rx_data_i = 1'b0, rx_clk_i = 1'b0;
    logic low_battery_i = 1'b0, signal_strength_i = 1'b0, data_quality_i = 1'b0;
    logic clock_recovery_lock_i = 1'b0, offset_sign_i = 1'b0;
    logic [3:0] rx_fifo_count_i = 4'h0, fifo_fill_level_i = 4'h4, offset_value_i = 4'h0;
    logic [15:0] cmd_word_i = 16'h0000, rd_data_o;
    logic [1:0] band_select_o;
    logic [3:0] crystal_load_select_o;
    logic tx_data_register_enable_o, rx_fifo_enable_o, rx_fifo_bit_o, rx_fifo_bit_valid_o;
    logic data_modulation_pin_o, data_modulation_pin_oe_o, recovered_clock_pin_o;
    logic recovered_clock_pin_oe_o, busy_o, done_o, offset_trusted_o;
    int err_total = 0, n_compared = 0, cyc_cnt = 0;

    tsc_link_if lnk ();
    tsc_device u_tsc_device (.mclk_i, .nrst_i, .link(lnk), .tx_mode_i, .tx_reg_ready_i,
        .tx_underrun_i, .rx_overflow_i, .wakeup_overflow_i, .ext_interrupt_data_indicator_pin_i,
        .afc_cycle_done_i, .rx_fifo_count_i, .fifo_fill_level_i, .low_battery_i,
        .signal_strength_i, .data_quality_i, .clock_recovery_lock_i, .offset_sign_i,
        .offset_value_i, .rx_data_i, .rx_clk_i, .tx_data_register_enable_o, .rx_fifo_enable_o,
        .band_select_o, .crystal_load_select_o, .rx_fifo_bit_o, .rx_fifo_bit_valid_o,
        .data_modulation_pin_o, .data_modulation_pin_oe_o, .recovered_clock_pin_o,
        .recovered_clock_pin_oe_o);
    tsc_host u_tsc_host (.mclk_i, .nrst_i, .link(lnk), .cmd_valid_i, .cmd_word_i,
        .afc_enable_i, .busy_o, .done_o, .rd_data_o, .offset_trusted_o);
    tsc_link_chk u_tsc_link_chk (.mclk_i, .nrst_i, .nsel(lnk.nsel), .sck(lnk.sck),
        .sdi(lnk.sdi), .sdo(lnk.sdo), .sdo_oe(lnk.sdo_oe), .sdo_line(lnk.sdo_line));

    // 10 MHz clock
    always #50 mclk_i = ~mclk_i;

    // Hang guard, far above the seventeen frames of this run
    always @(posedge mclk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            err_total++;
            summarize();
        end
    end

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One request, answer taken on the done edge; next request only once idle
    task automatic frame(input logic [15:0] w, output logic [15:0] rd);
        int n;
        @(posedge mclk_i);
        cmd_valid_i <= 1'b1;
        cmd_word_i <= w;
        @(posedge mclk_i);
        cmd_valid_i <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (done_o !== 1'b1 && n < 1000);
        rd = rd_data_o;
        while (busy_o !== 1'b0 && n < 1000) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 1000) begin
            err_total++;
            summarize();
        end
    endtask

    task automatic rd_sts(input logic [15:0] exp);
        logic [15:0] rd;
        frame(CMD_STATUS_READ, rd);
        check(rd, exp);
    endtask

    task automatic wr_cfg(input logic [7:0] v);
        logic [15:0] rd;
        frame({CMD_GEN_CFG, v}, rd);
    endtask

    task automatic cfg_is(input logic [7:0] exp);
        check({8'h00, tx_data_register_enable_o, rx_fifo_enable_o, band_select_o,
            crystal_load_select_o}, {8'h00, exp});
    endtask

    task automatic t_reset();
        cfg_is(GEN_CFG_RST[7:0]);
        rd_sts(16'h4200);
        check({15'h0, offset_trusted_o}, 16'h0000);
        rd_sts(16'h0200);
    endtask

    // Every band code, load code extremes, then writes that must not land
    task automatic t_config();
        logic [7:0] v;
        logic [15:0] rd;
        for (int i = 0; i < 4; i++) begin
            v = {i[1:0], i[1:0], 4'hf - 4'(i * 5)};
            wr_cfg(v);
            cfg_is(v);
        end
        frame(16'h8133, rd);
        cfg_is(8'hf0);
        frame(16'h0033, rd);
        cfg_is(8'hf0);
    endtask

    task automatic t_rx_flags();
        rx_fifo_count_i <= 4'h5;
        rx_overflow_i <= 1'b1;
        wakeup_overflow_i <= 1'b1;
        afc_cycle_done_i <= 1'b1;
        ext_interrupt_data_indicator_pin_i <= 1'b0;
        @(posedge mclk_i);
        {rx_overflow_i, wakeup_overflow_i, afc_cycle_done_i} <= 3'h0;
        rx_fifo_count_i <= 4'h0;
        repeat (4) @(posedge mclk_i);
        ext_interrupt_data_indicator_pin_i <= 1'b1;
        rd_sts(16'hba20);
        rd_sts(16'h0220);
    endtask

    // Ready ignored while the transmit register is off
    task automatic t_tx_flags();
        wr_cfg(8'h70);
        tx_mode_i <= 1'b1;
        tx_reg_ready_i <= 1'b1;
        @(posedge mclk_i);
        tx_reg_ready_i <= 1'b0;
        rd_sts(16'h0220);
        wr_cfg(8'hf0);
        tx_reg_ready_i <= 1'b1;
        tx_underrun_i <= 1'b1;
        @(posedge mclk_i);
        {tx_reg_ready_i, tx_underrun_i} <= 2'h0;
        rd_sts(16'ha220);
        tx_mode_i <= 1'b0;
    endtask

    task automatic t_live();
        {low_battery_i, signal_strength_i, data_quality_i, clock_recovery_lock_i} <= 4'hf;
        offset_sign_i <= 1'b1;
        offset_value_i <= 4'h9;
        rx_fifo_count_i <= 4'h2;
        afc_enable_i <= 1'b0;
        rd_sts(16'h05f9);
        check({15'h0, offset_trusted_o}, 16'h0001);
    endtask

    // Received bits go to the FIFO side or out on the pins, never both
    task automatic t_routing();
        wr_cfg(8'h48);
        rx_clk_i <= 1'b1;
        rx_data_i <= 1'b1;
        @(posedge mclk_i);
        rx_clk_i <= 1'b0;
        @(posedge mclk_i);
        check({12'h0, rx_fifo_bit_valid_o, rx_fifo_bit_o, data_modulation_pin_oe_o,
            recovered_clock_pin_oe_o}, 16'h000c);
        wr_cfg(8'h08);
        rx_clk_i <= 1'b1;
        @(posedge mclk_i);
        rx_clk_i <= 1'b0;
        @(posedge mclk_i);
        check({11'h0, rx_fifo_bit_valid_o, data_modulation_pin_oe_o, recovered_clock_pin_oe_o,
            data_modulation_pin_o, recovered_clock_pin_o}, 16'h000f);
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (12) @(posedge mclk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_config();
        t_rx_flags();
        t_tx_flags();
        t_live();
        t_routing();
        summarize();
    end
endmodule // transceiver_status_and_general_config_tb_top

// ### testbench/tsc_link_chk.sv
/*
 * Checker for the serial command wires between host and device end.
 * Assumes the host runs the default half period of eight clock cycles.
 */
`timescale 1ns/100ps
module tsc_link_chk (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // Link wires
    input wire logic nsel,
    input wire logic sck,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic sdo_line
);
    logic [4:0] rise_cnt_r;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    // Rising serial clocks seen in the current frame, cleared between frames
    always_ff @(posedge mclk_i) begin
        if (!nrst_i || nsel) begin
            rise_cnt_r <= 5'h00;
        end else if ($rose(sck)) begin
            rise_cnt_r <= rise_cnt_r + 5'h01;
        end
    end

    chk_frame_sixteen: assert property ($rose(nsel) |-> rise_cnt_r == 5'h10)
        else $error("frame closed without sixteen clock rises");
    chk_first_half: assert property ($fell(nsel) |-> !sck [*8])
        else $error("first serial clock rise too early");
    chk_drive_start: assert property ($fell(nsel) |-> ##[2:5] sdo_oe)
        else $error("device did not drive its data line after select");
    chk_drive_release: assert property ($rose(nsel) |-> ##[1:6] !sdo_oe)
        else $error("device kept driving after deselect");
    chk_sdo_hold: assert property (sck && $past(sck) |-> $stable(sdo))
        else $error("device data changed while serial clock high");
    chk_sdi_hold: assert property (sck && $past(sck) |-> $stable(sdi))
        else $error("host data changed while serial clock high");
    chk_idle_sck: assert property (nsel |-> !sck)
        else $error("serial clock high outside a frame");
    chk_gap_min: assert property ($rose(nsel) |-> nsel [*4])
        else $error("frames closer than four cycles");
    chk_idle_release: assert property (nsel && $past(nsel, 4) |-> !sdo_oe && sdo_line)
        else $error("device data line driven while deselected");
endmodule // tsc_link_chk
